// file: rtl/asc_defines.svh
// Register map, field layout, reset values and channel masks of the scan/compare block
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

`define ASC_ADDR_W          8
`define ASC_OFS_HIT_LOW     8'h00
`define ASC_OFS_SCAN_HIGH   8'h04
`define ASC_OFS_SCAN_LOW    8'h08
`define ASC_OFS_FMT_CTRL    8'h0c
`define ASC_OFS_RESULT      8'h10
`define ASC_OFS_IRQ_STATUS  8'h14
`define ASC_OFS_IRQ_MASK    8'h18

`define ASC_RST_HIT_LOW     16'h0000
`define ASC_RST_SCAN_HIGH   16'h0000
`define ASC_RST_SCAN_LOW    16'h0000
`define ASC_RST_FMT_CTRL    3'h0
`define ASC_RST_RESULT      16'h0000
`define ASC_RST_IRQ         2'h0

// Format control fields
`define ASC_FMT_SEL_LSB     0
`define ASC_FMT_SEL_MSB     1
`define ASC_FMT_12BIT_BIT   2

// Interrupt status fields
`define ASC_IRQ_MATCH_BIT   0
`define ASC_IRQ_WRITE_BIT   1

// Compare mode where buffer writes also set hit flags
`define ASC_CM_WRITE_OR_MATCH 2'h3

// Implemented-bit masks per package variant
`define ASC_MASK_LOW_FULL   16'hffff
`define ASC_MASK_LOW_28     16'hfe3f
`define ASC_MASK_LOW_20     16'hfe1f
`define ASC_MASK_HIGH_FULL  16'h7cff
`define ASC_MASK_HIGH_20    16'h7ce7

`endif

// file: rtl/asc_fmt_if.sv
// Link between the register block and the result formatter
`timescale 1ns/1ps
`default_nettype none
interface asc_fmt_if;
  logic [12:0]       raw_code;
  logic              raw_valid;
  logic              twelve_bit;
  asc_pkg::asc_fmt_t fmt;
  logic [15:0]       word;
  logic              word_valid;

  modport src (output raw_code, output raw_valid, output twelve_bit, output fmt,
               input word, input word_valid);
  modport fmt_end (input raw_code, input raw_valid, input twelve_bit, input fmt,
                   output word, output word_valid);
endinterface
`default_nettype wire

// file: rtl/asc_hit_bank.sv
// Sixteen compare hit flags, set by hardware and written by software
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"
module asc_hit_bank
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Converter events
  input  wire logic [1:0]  compare_mode_field,
  input  wire logic [15:0] match_evt,
  input  wire logic [15:0] buf_write_evt,
  input  wire logic [15:0] impl_mask,
  // Software access
  input  wire logic        sw_we,
  input  wire logic [15:0] sw_wdata,
  // Flags
  output logic      [15:0] hit_flag,
  output logic             any_match,
  output logic             any_write
);

  logic [15:0] set_vec;
  logic [15:0] next_hit;

  always_comb
  begin
    if (compare_mode_field == `ASC_CM_WRITE_OR_MATCH)
      set_vec = match_evt | buf_write_evt; // [R01]
    else
      set_vec = match_evt; // [R02]
    next_hit = sw_we ? sw_wdata : hit_flag;
    next_hit = (next_hit | set_vec) & impl_mask; // [R03] [R12]
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hit_flag <= `ASC_RST_HIT_LOW; // [R12]
    else
      hit_flag <= next_hit;
  end

  assign any_match = |(match_evt & impl_mask);
  assign any_write = |(buf_write_evt & impl_mask);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_match_sets_hit: assert property (match_evt != 16'h0000 // [R02]
    |=> (hit_flag & $past(match_evt & impl_mask)) == $past(match_evt & impl_mask))
    else $error("match did not set hit flag");
  a_write_mode_only: assert property (compare_mode_field != `ASC_CM_WRITE_OR_MATCH && !sw_we // [R01]
    && match_evt == 16'h0000 && buf_write_evt != 16'h0000 |=> $stable(hit_flag))
    else $error("buffer write set flag outside mode 11");
  a_write_sets_hit: assert property (compare_mode_field == `ASC_CM_WRITE_OR_MATCH // [R01]
    |=> (hit_flag & $past(buf_write_evt & impl_mask)) == $past(buf_write_evt & impl_mask))
    else $error("buffer write in mode 11 did not set flag");
  c_set_on_clear: cover property (sw_we && sw_wdata == 16'h0000 && match_evt != 16'h0000);

endmodule
`default_nettype wire

// file: rtl/asc_pkg.sv
// Types shared by the scan/compare/format block
package asc_pkg;

  typedef enum logic [1:0] {
    ASC_VAR_20PIN,
    ASC_VAR_28PIN,
    ASC_VAR_FULL
  } asc_variant_t;

  typedef enum logic [1:0] {
    ASC_FMT_INT,
    ASC_FMT_SINT,
    ASC_FMT_FRAC,
    ASC_FMT_SFRAC
  } asc_fmt_t;

endpackage

// file: rtl/asc_result_format.sv
// Turns a raw conversion code into a 16-bit bus word
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"
module asc_result_format
(
  // Clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // Code in, word out
  asc_fmt_if.fmt_end f
);

  logic [15:0] next_word;
  logic        sgn;

  always_comb
  begin
    next_word = 16'h0000;
    if (f.twelve_bit)
    begin
      sgn = f.raw_code[12];
      case (f.fmt)
        asc_pkg::ASC_FMT_INT:   next_word = {4'h0, f.raw_code[11:0]};
        asc_pkg::ASC_FMT_SINT:  next_word = {{4{sgn}}, f.raw_code[11:0]};
        asc_pkg::ASC_FMT_FRAC:  next_word = sgn ? 16'h0000 : {f.raw_code[11:0], 4'h0}; // [R10]
        asc_pkg::ASC_FMT_SFRAC: next_word = {sgn, f.raw_code[11:0], 3'h0}; // [R11]
        default:                next_word = 16'h0000;
      endcase
    end
    else
    begin
      sgn = f.raw_code[10];
      case (f.fmt)
        asc_pkg::ASC_FMT_INT:   next_word = {6'h00, f.raw_code[9:0]}; // [R09]
        asc_pkg::ASC_FMT_SINT:  next_word = {{6{sgn}}, f.raw_code[9:0]}; // [R09]
        asc_pkg::ASC_FMT_FRAC:  next_word = {f.raw_code[9:0], 6'h00}; // [R09]
        asc_pkg::ASC_FMT_SFRAC: next_word = {sgn, f.raw_code[9:0], 5'h00}; // [R09]
        default:                next_word = 16'h0000;
      endcase
    end
  end

  // Word held until the next valid code
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      f.word <= `ASC_RST_RESULT;
    else if (f.raw_valid)
      f.word <= next_word;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      f.word_valid <= 1'b0;
    else
      f.word_valid <= f.raw_valid;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_frac_neg_zero: assert property (f.raw_valid && f.twelve_bit && f.fmt == asc_pkg::ASC_FMT_FRAC // [R10]
    && f.raw_code[12] |=> f.word == 16'h0000)
    else $error("negative unsigned fraction not zero");
  a_sfrac_low_zero: assert property (f.raw_valid && f.twelve_bit && f.fmt == asc_pkg::ASC_FMT_SFRAC // [R11]
    |=> f.word[2:0] == 3'h0 && f.word[15] == $past(f.raw_code[12]))
    else $error("signed fraction layout wrong");
  a_int10_layout: assert property (f.raw_valid && !f.twelve_bit && f.fmt == asc_pkg::ASC_FMT_INT // [R09]
    |=> f.word == {6'h00, $past(f.raw_code[9:0])})
    else $error("10-bit integer layout wrong");
  a_sfrac10_layout: assert property (f.raw_valid && !f.twelve_bit && f.fmt == asc_pkg::ASC_FMT_SFRAC // [R09]
    |=> f.word == {$past(f.raw_code[10]), $past(f.raw_code[9:0]), 5'h00})
    else $error("10-bit signed fraction layout wrong");
  c_sfrac12: cover property (f.raw_valid && f.twelve_bit && f.fmt == asc_pkg::ASC_FMT_SFRAC);

endmodule
`default_nettype wire

// file: rtl/asc_top.sv
// Scan selection, compare hit flags and result formatting behind an APB slave
//
// What this block does
// [R01] In compare mode 11 a hit flag sets when its result buffer is written or matches, and stays set until software writes a zero.
// [R02] In every other compare mode a hit flag sets only on a compare match of its channel.
// [R03] Hit flags and scan bits of channels the variant lacks always read zero.
// [R04] High scan word bits 14-10 pick channels 30-26, bits 7-0 channels 23-16; bits 15 and 9-8 read zero.
// [R05] Each low scan word bit 15-0 includes (one) or skips (zero) the analog input of that number.
// [R06] Software should never scan channels the variant lacks, since their results are indeterminate.
// [R07] The smallest variant lacks hit and low scan bits 8-5 and high scan channels 20 and 19.
// [R08] The mid-size variant lacks hit and low scan bits 8-6.
// [R09] A 10-bit result reads as integer, signed integer, fraction or signed fraction in set layouts.
// [R10] Unsigned 12-bit fraction puts the code in bits 15-4, and any negative input gives zero.
// [R11] Signed 12-bit fraction puts the sign at bit 15, code beneath, three low zeros.
// [R12] All implemented hit and scan bits are read/write and clear after power-on reset.
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"
module asc_top
#(
  parameter asc_pkg::asc_variant_t VARIANT = asc_pkg::ASC_VAR_FULL,
  parameter int                    CODE_W  = 13
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Converter side
  input  wire logic [1:0]  compare_mode_field,
  input  wire logic [15:0] match_evt,
  input  wire logic [15:0] buf_write_evt,
  input  wire logic [12:0] raw_code,
  input  wire logic        raw_valid,
  output logic      [31:0] scan_include_bit,
  output logic      [15:0] result_word,
  output logic             result_valid,
  // Interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks and variant masks

  generate
    if (CODE_W != 13)
    begin : g_bad_width
      $error("asc_top supports only a 13-bit raw code");
    end
    if (VARIANT != asc_pkg::ASC_VAR_20PIN && VARIANT != asc_pkg::ASC_VAR_28PIN && VARIANT != asc_pkg::ASC_VAR_FULL)
    begin : g_bad_variant
      $error("asc_top supports only the three package variants");
    end
  endgenerate

  function automatic logic [15:0] low_mask(input asc_pkg::asc_variant_t v);
    case (v)
      asc_pkg::ASC_VAR_20PIN: low_mask = `ASC_MASK_LOW_20; // [R07]
      asc_pkg::ASC_VAR_28PIN: low_mask = `ASC_MASK_LOW_28; // [R08]
      default:                low_mask = `ASC_MASK_LOW_FULL;
    endcase
  endfunction

  function automatic logic [15:0] high_mask(input asc_pkg::asc_variant_t v);
    if (v == asc_pkg::ASC_VAR_20PIN)
      high_mask = `ASC_MASK_HIGH_20; // [R07]
    else
      high_mask = `ASC_MASK_HIGH_FULL; // [R04]
  endfunction

  localparam logic [15:0] LOW_MASK  = low_mask(VARIANT);
  localparam logic [15:0] HIGH_MASK = high_mask(VARIANT);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic        wr_en;
  logic        rd_en;
  logic        hit_sel;
  logic        shi_sel;
  logic        slo_sel;
  logic        fmt_sel;
  logic        res_sel;
  logic        ist_sel;
  logic        imk_sel;
  logic        mapped;

  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  assign pready = 1'b1;

  always_comb
  begin
    hit_sel = 1'b0;
    shi_sel = 1'b0;
    slo_sel = 1'b0;
    fmt_sel = 1'b0;
    res_sel = 1'b0;
    ist_sel = 1'b0;
    imk_sel = 1'b0;
    if (paddr == `ASC_OFS_HIT_LOW)
      hit_sel = 1'b1;
    else if (paddr == `ASC_OFS_SCAN_HIGH)
      shi_sel = 1'b1;
    else if (paddr == `ASC_OFS_SCAN_LOW)
      slo_sel = 1'b1;
    else if (paddr == `ASC_OFS_FMT_CTRL)
      fmt_sel = 1'b1;
    else if (paddr == `ASC_OFS_RESULT)
      res_sel = 1'b1;
    else if (paddr == `ASC_OFS_IRQ_STATUS)
      ist_sel = 1'b1;
    else if (paddr == `ASC_OFS_IRQ_MASK)
      imk_sel = 1'b1;
    mapped = hit_sel | shi_sel | slo_sel | fmt_sel | res_sel | ist_sel | imk_sel;
  end

  // Unmapped addresses answer with an error, writes are dropped
  assign pslverr = psel && penable && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Scan selection registers

  logic [15:0] scan_high;
  logic [15:0] scan_low;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      scan_high <= `ASC_RST_SCAN_HIGH; // [R12]
    else if (wr_en && shi_sel)
      scan_high <= pwdata[15:0] & HIGH_MASK; // [R03] [R04]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      scan_low <= `ASC_RST_SCAN_LOW; // [R12]
    else if (wr_en && slo_sel)
      scan_low <= pwdata[15:0] & LOW_MASK; // [R03] [R05]
  end

  // Channel n of the scan list is bit n; gaps of the high word stay zero
  assign scan_include_bit = {1'b0, scan_high[14:10], 2'b00, scan_high[7:0], scan_low}; // [R04] [R05]

  ////////////////////////////////////////////////////////////////////////////
  // Compare hit flags

  logic [15:0] hit_flag;
  logic        any_match;
  logic        any_write;

  asc_hit_bank u_hits
  (
    .pclk               (pclk),
    .presetn            (presetn),
    .compare_mode_field (compare_mode_field),
    .match_evt          (match_evt),
    .buf_write_evt      (buf_write_evt),
    .impl_mask          (LOW_MASK),
    .sw_we              (wr_en && hit_sel),
    .sw_wdata           (pwdata[15:0]),
    .hit_flag           (hit_flag),
    .any_match          (any_match),
    .any_write          (any_write)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result format control and formatter

  logic [2:0] fmt_ctrl;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fmt_ctrl <= `ASC_RST_FMT_CTRL;
    else if (wr_en && fmt_sel)
      fmt_ctrl <= pwdata[2:0];
  end

  asc_fmt_if fmt_link ();

  assign fmt_link.raw_code   = raw_code;
  assign fmt_link.raw_valid  = raw_valid;
  assign fmt_link.twelve_bit = fmt_ctrl[`ASC_FMT_12BIT_BIT];
  assign fmt_link.fmt        = asc_pkg::asc_fmt_t'(fmt_ctrl[`ASC_FMT_SEL_MSB:`ASC_FMT_SEL_LSB]);

  asc_result_format u_fmt
  (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (fmt_link.fmt_end)
  );

  assign result_word  = fmt_link.word;
  assign result_valid = fmt_link.word_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  assign irq_set = {any_write, any_match};
  assign irq_clr = (wr_en && ist_sel) ? pwdata[1:0] : 2'b00;

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status <= `ASC_RST_IRQ;
    else
      irq_status <= (irq_status & ~irq_clr) | irq_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= `ASC_RST_IRQ;
    else if (wr_en && imk_sel)
      irq_mask <= pwdata[1:0];
  end

  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd_en)
    begin
      if (hit_sel)
        prdata = {16'h0000, hit_flag}; // [R03]
      else if (shi_sel)
        prdata = {16'h0000, scan_high}; // [R04]
      else if (slo_sel)
        prdata = {16'h0000, scan_low}; // [R05]
      else if (fmt_sel)
        prdata = {29'h0000_0000, fmt_ctrl};
      else if (res_sel)
        prdata = {16'h0000, fmt_link.word};
      else if (ist_sel)
        prdata = {30'h0000_0000, irq_status};
      else if (imk_sel)
        prdata = {30'h0000_0000, irq_mask};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_hit_unimpl_zero: assert property ((hit_flag & ~LOW_MASK) == 16'h0000) // [R03]
    else $error("unimplemented hit bit set");
  a_scan_gap_zero: assert property (scan_include_bit[31] == 1'b0 // [R04]
    && scan_include_bit[25:24] == 2'b00 && (scan_high & ~HIGH_MASK) == 16'h0000)
    else $error("reserved scan bits not zero");
  a_scan_low_write: assert property (wr_en && slo_sel // [R05]
    |=> scan_low == ($past(pwdata[15:0]) & LOW_MASK))
    else $error("low scan word write lost");
  a_scan_high_map: assert property (wr_en && shi_sel ##1 !(wr_en && shi_sel) // [R04]
    |-> scan_include_bit[30:26] == ($past(pwdata[14:10]) & HIGH_MASK[14:10]))
    else $error("high scan word mapping wrong");
  a_hit_readback: assert property (rd_en && hit_sel |-> prdata == {16'h0000, hit_flag}) // [R12]
    else $error("hit flag read wrong");
  a_irq_sticky: assert property (any_match |=> irq_status[`ASC_IRQ_MATCH_BIT] [*1])
    else $error("match event not latched");
  a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  // Register writes, holds and reads
  a_scan_high_write: assert property (wr_en && shi_sel // [R04]
    |=> scan_high == ($past(pwdata[15:0]) & HIGH_MASK))
    else $error("high scan word write lost");
  a_scan_high_hold: assert property (!(wr_en && shi_sel) |=> $stable(scan_high)) // [R04]
    else $error("high scan word changed unasked");
  a_scan_low_hold: assert property (!(wr_en && slo_sel) |=> $stable(scan_low)) // [R05]
    else $error("low scan word changed unasked");
  a_scan_low_read: assert property (rd_en && slo_sel |-> prdata == {16'h0000, scan_low}) // [R05]
    else $error("low scan word read wrong");
  a_hit_sw_write: assert property (wr_en && hit_sel // [R12]
    |=> (hit_flag & ~$past(match_evt | buf_write_evt))
        == ($past(pwdata[15:0]) & LOW_MASK & ~$past(match_evt | buf_write_evt)))
    else $error("hit flag write lost");
  a_hit_hold: assert property (!(wr_en && hit_sel) && match_evt == 16'h0000 // [R02]
    && buf_write_evt == 16'h0000 |=> $stable(hit_flag))
    else $error("hit flag changed without cause");

  // Result path
  a_fmt_ctrl_write: assert property (wr_en && fmt_sel |=> fmt_ctrl == $past(pwdata[2:0]))
    else $error("format control write lost");
  a_fmt_ctrl_hold: assert property (!(wr_en && fmt_sel) |=> $stable(fmt_ctrl))
    else $error("format control changed unasked");
  a_result_ro: assert property (wr_en && res_sel && !raw_valid |=> $stable(result_word))
    else $error("result word changed by a write");
  a_result_reg_read: assert property (rd_en && res_sel |-> prdata == {16'h0000, result_word})
    else $error("result register read wrong");
  a_result_valid: assert property (raw_valid |=> result_valid)
    else $error("result valid missing");
  a_result_quiet: assert property (!raw_valid |=> !result_valid)
    else $error("result valid without a code");

  // Interrupt status and mask
  a_irq_mask_write: assert property (wr_en && imk_sel |=> irq_mask == $past(pwdata[1:0]))
    else $error("interrupt mask write lost");
  a_irq_mask_hold: assert property (!(wr_en && imk_sel) |=> $stable(irq_mask))
    else $error("interrupt mask changed unasked");
  a_irq_set_wins: assert property (irq_set != 2'b00
    |=> (irq_status & $past(irq_set)) == $past(irq_set))
    else $error("interrupt event lost");
  a_irq_clear: assert property (wr_en && ist_sel && irq_set == 2'b00
    |=> (irq_status & $past(pwdata[1:0])) == 2'b00)
    else $error("interrupt status not cleared");
  a_irq_hold: assert property (irq_set == 2'b00 && !(wr_en && ist_sel) |=> $stable(irq_status))
    else $error("interrupt status changed unasked");

  // Bus answers
  a_unmapped_no_write: assert property (psel && penable && pwrite && !mapped
    |=> $stable(scan_high) && $stable(scan_low) && $stable(fmt_ctrl) && $stable(irq_mask))
    else $error("unmapped write changed a register");
  a_read_idle_zero: assert property (!rd_en |-> prdata == 32'h0000_0000)
    else $error("read data outside a read");
  a_mapped_no_err: assert property (psel && penable && mapped |-> !pslverr)
    else $error("mapped access refused");

  c_mode11_write: cover property (compare_mode_field == `ASC_CM_WRITE_OR_MATCH && buf_write_evt != 16'h0000);
  c_irq_raised: cover property (!irq ##1 irq);
  c_scan_full: cover property (scan_low == LOW_MASK);

endmodule
`default_nettype wire

// file: verification/asc_top_tb.sv
// Self-checking bench of the scan/compare/format block over APB
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"
module asc_top_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [1:0]  compare_mode_field;
  logic [15:0] match_evt;
  logic [15:0] buf_write_evt;
  logic [12:0] raw_code;
  logic        raw_valid;
  wire  [31:0] prdata0;
  wire  [31:0] prdata1;
  wire  [31:0] prdata2;
  wire  [31:0] scan0;
  wire  [31:0] scan2;
  wire  [15:0] result_word;
  wire         pready;
  wire         pslverr;
  wire         result_valid;
  wire         irq;
  logic [31:0] rd0;
  logic [31:0] rd1;
  logic [31:0] rd2;
  logic        rerr;
  int          failures;
  int          num_checks;
  int          cycles;
  logic [15:0] masks [3][3] = '{'{16'hffff, 16'h7cff, 16'hffff}, '{16'hfe3f, 16'h7cff, 16'hfe3f},
                                '{16'hfe1f, 16'h7ce7, 16'hfe1f}};
  logic [7:0]  regs [3] = '{`ASC_OFS_HIT_LOW, `ASC_OFS_SCAN_HIGH, `ASC_OFS_SCAN_LOW};
  logic [15:0] pats [3] = '{16'hffff, 16'h5a5a, 16'h0000};
  logic [12:0] codes [4] = '{13'h0155, 13'h0600, 13'h0fff, 13'h1fff};
  logic [15:0] fexp [16] = '{16'h0155, 16'h0155, 16'h5540, 16'h2aa0, 16'h0200, 16'hfe00, 16'h8000, 16'hc000,
                             16'h0fff, 16'h0fff, 16'hfff0, 16'h7ff8, 16'h0fff, 16'hffff, 16'h0000, 16'hfff8};

  ////////////////////////////////////////////////////////////////////////////
  // Three package variants on one shared bus
  asc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata0), .pready(pready), .pslverr(pslverr),
    .compare_mode_field(compare_mode_field), .match_evt(match_evt), .buf_write_evt(buf_write_evt),
    .raw_code(raw_code), .raw_valid(raw_valid), .scan_include_bit(scan0), .result_word(result_word),
    .result_valid(result_valid), .irq(irq));
  asc_top #(.VARIANT(asc_pkg::ASC_VAR_28PIN)) u_dut28 (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata1), .pready(),
    .pslverr(), .compare_mode_field(compare_mode_field), .match_evt(match_evt), .buf_write_evt(buf_write_evt),
    .raw_code(raw_code), .raw_valid(raw_valid), .scan_include_bit(), .result_word(), .result_valid(), .irq());
  asc_top #(.VARIANT(asc_pkg::ASC_VAR_20PIN)) u_dut20 (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata2), .pready(),
    .pslverr(), .compare_mode_field(compare_mode_field), .match_evt(match_evt), .buf_write_evt(buf_write_evt),
    .raw_code(raw_code), .raw_valid(raw_valid), .scan_include_bit(scan2), .result_word(), .result_valid(),
    .irq());

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic give_verdict();
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1);
    chk("access cycles", 32'h1, n);
    rd0     = prdata0;
    rd1     = prdata1;
    rd2     = prdata2;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input logic [15:0] m, input logic [15:0] b);
    @(posedge pclk);
    match_evt     <= m;
    buf_write_evt <= b;
    @(posedge pclk);
    match_evt     <= 16'h0000;
    buf_write_evt <= 16'h0000;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock, reset and timeout
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {compare_mode_field, match_evt, buf_write_evt, raw_code, raw_valid} = '0;
    {failures, num_checks, cycles} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int r = 0; r < 3; r++)
    begin
      apb(1'b0, regs[r], 32'h0);
      chk("reset value", 32'h0, rd0 | rd1 | rd2);
    end
    chk("scan include after reset", 32'h0, scan0);
    // Patterns through the hit and scan registers of every variant
    for (int p = 0; p < 3; p++)
    begin
      for (int r = 0; r < 3; r++)
        apb(1'b1, regs[r], {16'h0, pats[p]});
      for (int r = 0; r < 3; r++)
      begin
        apb(1'b0, regs[r], 32'h0);
        chk("full variant reg", {16'h0, pats[p] & masks[0][r]}, rd0);
        chk("mid variant reg", {16'h0, pats[p] & masks[1][r]}, rd1);
        chk("small variant reg", {16'h0, pats[p] & masks[2][r]}, rd2);
      end
      chk("full scan include", {pats[p] & masks[0][1], pats[p] & masks[0][2]}, scan0);
      chk("small scan include", {pats[p] & masks[2][1], pats[p] & masks[2][2]}, scan2);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rd0);
    // Compare hits in modes 00 to 10, then in mode 11
    for (int m = 0; m < 3; m++)
    begin
      compare_mode_field <= m[1:0];
      pulse(16'h0088, 16'h0010);
      apb(1'b0, `ASC_OFS_HIT_LOW, 32'h0);
      chk("hit on match only", 32'h0088, rd0);
      chk("small hit lacks channel 7", 32'h0008, rd2);
      chk("mid hit lacks channel 7", 32'h0008, rd1);
      apb(1'b1, `ASC_OFS_HIT_LOW, 32'h0);
    end
    compare_mode_field <= 2'h3;
    apb(1'b0, `ASC_OFS_HIT_LOW, 32'h0);
    chk("hit clear before write", 32'h0, rd0);
    pulse(16'h0000, 16'h0010);
    apb(1'b0, `ASC_OFS_HIT_LOW, 32'h0);
    chk("hit on buffer write", 32'h0010, rd0);
    pulse(16'h0200, 16'h0000);
    apb(1'b0, `ASC_OFS_HIT_LOW, 32'h0);
    chk("hit on match in mode 11", 32'h0210, rd0);
    // Interrupt status, mask and clear
    @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, `ASC_OFS_IRQ_MASK, 32'h1);
    apb(1'b0, `ASC_OFS_IRQ_STATUS, 32'h0);
    chk("irq status", 32'h3, rd0);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    apb(1'b1, `ASC_OFS_IRQ_STATUS, 32'h1);
    @(posedge pclk);
    chk("irq after clear", 32'h0, {31'h0, irq});
    apb(1'b1, `ASC_OFS_IRQ_STATUS, 32'h2);
    apb(1'b0, `ASC_OFS_IRQ_STATUS, 32'h0);
    chk("irq status cleared", 32'h0, rd0);
    // Result formats, 10-bit then 12-bit
    for (int i = 0; i < 16; i++)
    begin
      int n;
      apb(1'b1, `ASC_OFS_FMT_CTRL, {29'h0, i[3], i[1:0]});
      @(posedge pclk);
      raw_code  <= codes[i / 4];
      raw_valid <= 1'b1;
      @(posedge pclk);
      raw_valid <= 1'b0;
      n = 0;
      do
      begin
        @(posedge pclk);
        n++;
      end
      while (result_valid !== 1'b1);
      chk("result latency", 32'h1, n);
      chk("result word", {16'h0, fexp[i]}, {16'h0, result_word});
      apb(1'b0, `ASC_OFS_RESULT, 32'h0);
      chk("result register", {16'h0, fexp[i]}, rd0);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
